// File: capsc_consts.vh
// constants for the capacitive sensing control block
`ifndef CAPSC_CONSTS_VH
`define CAPSC_CONSTS_VH
// ====================
// register indices
`define CAPSC_ADDR_CTRL0 2'h0
`define CAPSC_ADDR_CTRL1 2'h1
`define CAPSC_ADDR_TCFG 2'h2
`define CAPSC_ADDR_TMR1 2'h3
`define CAPSC_ADDR_TMR0 2'h3
// ====================
// control 0 fields
`define CAPSC_B_EN 7
`define CAPSC_B_RM 6
`define CAPSC_B_RNG_HI 3
`define CAPSC_B_RNG_LO 2
`define CAPSC_B_DIR 1
`define CAPSC_B_T0X 0
`define CAPSC_CTRL0_WMASK 8'hcd
`define CAPSC_RST_BYTE 8'h00
// ====================
// timer config fields (offset 2)
`define CAPSC_B_T0CS 0
`define CAPSC_B_T1ON 1
`define CAPSC_B_T1GE 2
`define CAPSC_B_T1CS_LO 3
`define CAPSC_B_T1CS_HI 4
`define CAPSC_B_T0RD 5
`define CAPSC_T1CS_OSC 2'h3
// ====================
// range codes
`define CAPSC_RNG_OFF 2'h0
`define CAPSC_RNG_LOW 2'h1
`define CAPSC_RNG_MED 2'h2
`define CAPSC_RNG_HIGH 2'h3
`define CAPSC_CH_LAST 4'h7
`endif

// File: capsc_edge_sync.v
// two-stage synchroniser with rising edge pulse
`timescale 1ns/1ps
module capsc_edge_sync (
  input wire clk_sys,
  input wire rst,
  input wire din,
  output wire rise
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r;
endmodule // capsc_edge_sync

// File: capsc_counter.v
// counter with enable, clear and next value
`timescale 1ns/1ps
module capsc_counter #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire clr,
  input wire inc,
  output reg [W-1:0] count_r
);
  wire [W-1:0] count_nxt;
  assign count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r <= {W{1'b0}};
    end else if (clr) begin
      count_r <= {W{1'b0}};
    end else if (inc) begin
      count_r <= count_nxt;
    end
  end
endmodule // capsc_counter

// File: capsc_ctrl.v
// capacitive sensing control registers, oscillator steering and timer counting
`timescale 1ns/1ps
`include "capsc_consts.vh"
module capsc_ctrl (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire sleep,
  input wire osc_out,
  input wire osc_dir,
  input wire timer0_ext_pin,
  input wire t1_gate,
  output reg osc_on,
  output reg src_enable,
  output reg var_ref,
  output reg [1:0] range_level,
  output reg [7:0] chan_connect
);
  // ==================================================
  // register state
  reg sense_enable_r;
  reg ref_mode_select_r;
  reg [1:0] current_range_select_r;
  reg timer0_ext_source_select_r;
  reg [3:0] channel_select_r;
  reg timer0_clock_source_r;
  reg timer1_on_r;
  reg timer1_gate_enable_r;
  reg [1:0] timer1_clock_source_r;
  reg t0_read_sel_r;
  reg osc_dir_r;
  reg osc_dir_nxt;
  reg [7:0] ctrl0_rd;
  wire osc_rise;
  wire t0pin_rise;
  wire [15:0] t1_count;
  wire [15:0] t0_count;
  reg t1_inc;
  reg t0_inc;
  wire t1_clr;
  wire t0_clr;

  // ==================================================
  // register writes
  // all bits clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sense_enable_r <= 1'b0;
      ref_mode_select_r <= 1'b0;
      current_range_select_r <= 2'h0;
      timer0_ext_source_select_r <= 1'b0;
      channel_select_r <= 4'h0;
      timer0_clock_source_r <= 1'b0;
      timer1_on_r <= 1'b0;
      timer1_gate_enable_r <= 1'b0;
      timer1_clock_source_r <= 2'h0;
      t0_read_sel_r <= 1'b0;
    end else if (wr) begin
      if (addr == `CAPSC_ADDR_CTRL0) begin
        sense_enable_r <= wdata[`CAPSC_B_EN];
        ref_mode_select_r <= wdata[`CAPSC_B_RM];
        current_range_select_r <= wdata[`CAPSC_B_RNG_HI:`CAPSC_B_RNG_LO];
        timer0_ext_source_select_r <= wdata[`CAPSC_B_T0X];
      end else if (addr == `CAPSC_ADDR_CTRL1) begin
        channel_select_r <= wdata[3:0];
      end else if (addr == `CAPSC_ADDR_TCFG) begin
        timer0_clock_source_r <= wdata[`CAPSC_B_T0CS];
        timer1_on_r <= wdata[`CAPSC_B_T1ON];
        timer1_gate_enable_r <= wdata[`CAPSC_B_T1GE];
        timer1_clock_source_r <= wdata[`CAPSC_B_T1CS_HI:`CAPSC_B_T1CS_LO];
        t0_read_sel_r <= wdata[`CAPSC_B_T0RD];
      end
    end
  end

  // ==================================================
  // oscillator direction status
  always @* begin
    osc_dir_nxt = osc_dir & osc_on;
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_dir_r <= 1'b0;
    end else begin
      osc_dir_r <= osc_dir_nxt;
    end
  end

  // ==================================================
  // analog steering
  always @* begin
    osc_on = 1'b0;
    src_enable = 1'b0;
    range_level = `CAPSC_RNG_OFF;
    var_ref = ref_mode_select_r;
    chan_connect = 8'h00;
    if (sense_enable_r) begin
      if (ref_mode_select_r) begin
        osc_on = 1'b1;
        src_enable = (current_range_select_r != `CAPSC_RNG_OFF);
        range_level = current_range_select_r;
      end else begin
        osc_on = (current_range_select_r != `CAPSC_RNG_OFF);
        src_enable = osc_on;
        range_level = current_range_select_r;
      end
      if (channel_select_r <= `CAPSC_CH_LAST) begin
        chan_connect = 8'h01 << channel_select_r[2:0];
      end
    end
  end

  // ==================================================
  // timer clock selection
  capsc_edge_sync u_osc_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(osc_out),
    .rise(osc_rise)
  );
  capsc_edge_sync u_t0pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(timer0_ext_pin),
    .rise(t0pin_rise)
  );

  always @* begin
    t1_inc = 1'b0;
    if (timer1_on_r && (!timer1_gate_enable_r || t1_gate)) begin
      if (timer1_clock_source_r == `CAPSC_T1CS_OSC) begin
        t1_inc = osc_rise;
      end else begin
        t1_inc = 1'b1;
      end
    end
  end

  always @* begin
    t0_inc = 1'b0;
    if (!sleep) begin
      if (timer0_clock_source_r) begin
        t0_inc = timer0_ext_source_select_r ? osc_rise : t0pin_rise;
      end else begin
        t0_inc = 1'b1;
      end
    end
  end

  // writing the count register clears the selected timer
  assign t1_clr = wr && (addr == `CAPSC_ADDR_TMR1) && !t0_read_sel_r;
  assign t0_clr = wr && (addr == `CAPSC_ADDR_TMR0) && t0_read_sel_r;

  capsc_counter #(.W(16)) u_t1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(t1_clr),
    .inc(t1_inc),
    .count_r(t1_count)
  );
  capsc_counter #(.W(16)) u_t0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(t0_clr),
    .inc(t0_inc),
    .count_r(t0_count)
  );

  // ==================================================
  // read back
  always @* begin
    ctrl0_rd = `CAPSC_RST_BYTE;
    ctrl0_rd[`CAPSC_B_EN] = sense_enable_r;
    ctrl0_rd[`CAPSC_B_RM] = ref_mode_select_r;
    ctrl0_rd[`CAPSC_B_RNG_HI:`CAPSC_B_RNG_LO] = current_range_select_r;
    ctrl0_rd[`CAPSC_B_DIR] = osc_dir_r;
    ctrl0_rd[`CAPSC_B_T0X] = timer0_ext_source_select_r;
  end

  // control 0 bits 5 and 4 read zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == `CAPSC_ADDR_CTRL0) begin
        rdata <= ctrl0_rd;
      end else if (addr == `CAPSC_ADDR_CTRL1) begin
        rdata <= {4'h0, channel_select_r};
      end else if (addr == `CAPSC_ADDR_TCFG) begin
        rdata <= {2'h0, t0_read_sel_r, timer1_clock_source_r, timer1_gate_enable_r,
                  timer1_on_r, timer0_clock_source_r};
      end else begin
        rdata <= t0_read_sel_r ? t0_count[7:0] : t1_count[7:0];
      end
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // capsc_ctrl

// File: capsc_monitor.sv
// checker for register readback and oscillator steering outputs
`timescale 1ns/1ps
module capsc_monitor (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire osc_on,
  input wire osc_dir,
  input wire src_enable,
  input wire var_ref,
  input wire [1:0] range_level,
  input wire [7:0] chan_connect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // =====================
  // control writes with the module enabled
  sequence s_en_wr;
    wr && addr == 2'h0 && wdata[7];
  endsequence
  property p_unimpl; rd && addr == 2'h0 |=> rdata[5:4] == 2'b00; endproperty
  property p_range; s_en_wr |=> range_level == $past(wdata[3:2]); endproperty
  property p_ref; s_en_wr |=> var_ref == $past(wdata[6]); endproperty
  property p_fix_off; s_en_wr ##0 wdata[6:2] == 5'h00 |=> !osc_on; endproperty
  property p_noise; s_en_wr ##0 wdata[6] && wdata[3:2] == 2'h0 |=> osc_on && !src_enable;
  endproperty
  property p_run; s_en_wr ##0 wdata[3:2] != 2'h0 |=> osc_on && src_enable; endproperty
  property p_dis; wr && addr == 2'h0 && !wdata[7] |=> chan_connect == 8'h00 && !osc_on;
  endproperty
  property p_resv; wr && addr == 2'h1 && wdata[3] |=> chan_connect == 8'h00; endproperty
  property p_hold; !wr |=> $stable(range_level) && $stable(var_ref); endproperty
  property p_dir; rd && addr == 2'h0 |=> rdata[1] == $past(osc_dir && osc_on, 2); endproperty
  a_unimpl: assert property (p_unimpl) else $error("reserved bits read nonzero");
  a_range: assert property (p_range) else $error("range level wrong");
  a_ref: assert property (p_ref) else $error("reference select wrong");
  a_fix_off: assert property (p_fix_off) else $error("fixed code 00 not off");
  a_noise: assert property (p_noise) else $error("noise mode wrong");
  a_run: assert property (p_run) else $error("enabled range not running");
  a_dis: assert property (p_dis) else $error("disabled module still active");
  a_resv: assert property (p_resv) else $error("reserved channel connected");
  a_hold: assert property (p_hold) else $error("steering changed without write");
  a_dir: assert property (p_dir) else $error("direction status wrong");
endmodule // capsc_monitor
bind capsc_ctrl capsc_monitor capsc_monitor_i (.clk_sys, .rst, .addr, .wdata, .wr, .rd,
  .rdata, .osc_on, .osc_dir, .src_enable, .var_ref, .range_level, .chan_connect);

// File: capsc_pad_model.sv
// sensing pad oscillator seen from the control block
`timescale 1ns/1ps
module capsc_pad_model #(
  parameter HALF_NS = 80
) (
  input wire osc_on,
  output reg osc_out,
  output reg osc_dir
);
  // ======================
  // oscillation, phase kept off the clock edges
  initial begin
    osc_out = 1'b0;
    osc_dir = 1'b0;
    forever begin
      wait (osc_on);
      #3;
      while (osc_on) begin
        #(HALF_NS);
        // no late edge once switched off
        if (osc_on) begin
          osc_out = ~osc_out;
          osc_dir = ~osc_out;
        end
      end
      osc_dir = 1'b0;
    end
  end
endmodule // capsc_pad_model

// File: tb_top.sv
// testbench for the capacitive sensing control block
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, rst, wr, rd, sleep, timer0_ext_pin, t1_gate;
  reg [1:0] addr;
  reg [7:0] wdata, v0, v1;
  wire [7:0] rdata, chan_connect;
  wire osc_out, osc_dir, osc_on, src_enable, var_ref;
  wire [1:0] range_level;
  integer err_total, n_checks, cyc, i;
  capsc_ctrl capsc_ctrl_i (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata, .sleep, .osc_out,
    .osc_dir, .timer0_ext_pin, .t1_gate, .osc_on, .src_enable, .var_ref, .range_level,
    .chan_connect);
  capsc_pad_model capsc_pad_model_i (.osc_on, .osc_out, .osc_dir);
  // ======================
  // access and compare tasks
  task results;
    begin
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
    end
  endtask
  task rd_reg(input [1:0] a, output [7:0] v);
    begin
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      v = rdata;
    end
  endtask
  task zchk;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rd_reg(i[1:0], v0);
        chk(v0, 8'h00);
      end
      chk({osc_on, src_enable, var_ref, range_level}, 5'h00);
      chk(chan_connect, 8'h00);
    end
  endtask
  // selected timer count gained over 64 cycles
  task mrun(input [7:0] c, input s, input g, input [7:0] e);
    begin
      @(posedge clk_sys);
      sleep <= s;
      t1_gate <= g;
      wr_reg(2'h2, c);
      rd_reg(2'h3, v0);
      repeat (62) @(posedge clk_sys);
      rd_reg(2'h3, v1);
      v1 = v1 - v0;
      chk(v1, e);
    end
  endtask
  // ======================
  // clock, pin stimulus, timeout
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    timer0_ext_pin = 1'b0;
    forever #80 timer0_ext_pin = ~timer0_ext_pin;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      results;
    end
  end
  // ======================
  // main sequence
  initial begin
    {rst, wr, rd, sleep, t1_gate, addr, wdata} = {5'h10, 2'h0, 8'h00};
    {err_total, n_checks, cyc} = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    zchk;
    wr_reg(2'h0, 8'hff);
    rd_reg(2'h0, v0);
    chk(v0 & 8'hfd, 8'hcd);
    for (i = 0; i < 8; i = i + 1) begin
      wr_reg(2'h0, {1'b1, i[2], 2'b00, i[1:0], 2'b00});
      chk({osc_on, src_enable, range_level}, {i[2] | (i[1:0] != 0), i[1:0] != 0, i[1:0]});
      chk({7'h0, var_ref}, {7'h0, i[2]});
    end
    for (i = 0; i < 16; i = i + 1) begin
      wr_reg(2'h1, i[7:0]);
      chk(chan_connect, i < 8 ? 8'h01 << i : 8'h00);
    end
    wr_reg(2'h0, 8'h0c);
    chk({7'h0, osc_on}, 8'h00);
    chk(chan_connect, 8'h00);
    rd_reg(2'h0, v0);
    chk(v0, 8'h0c);
    wr_reg(2'h0, 8'h8d);
    mrun(8'h02, 1'b0, 1'b0, 8'h40);
    wr_reg(2'h2, 8'h00);
    wr_reg(2'h3, 8'h00);
    rd_reg(2'h3, v0);
    chk(v0, 8'h00);
    mrun(8'h06, 1'b0, 1'b0, 8'h00);
    mrun(8'h06, 1'b0, 1'b1, 8'h40);
    mrun(8'h1a, 1'b0, 1'b0, 8'h08);
    mrun(8'h1a, 1'b1, 1'b0, 8'h08);
    mrun(8'h21, 1'b0, 1'b0, 8'h08);
    mrun(8'h21, 1'b1, 1'b0, 8'h00);
    mrun(8'h20, 1'b0, 1'b0, 8'h40);
    wr_reg(2'h0, 8'h8c);
    mrun(8'h21, 1'b0, 1'b0, 8'h08);
    wr_reg(2'h0, 8'hff);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    zchk;
    results;
  end
endmodule // tb_top
